// file: logic/pmsi_defines.svh
/*
 * Constants of the power-manager serial status block: bus address, register
 * indices, reset values, bit groups and timing counts.
 * Assumes it is included by bare name from the top module and the bus master model.
 */
`ifndef PMSI_DEFINES_SVH
`define PMSI_DEFINES_SVH

// fixed upper six bits of the 7-bit bus address (binary 100100)
`define PMSI_ADDR_FIXED 6'h24

// register indices
`define PMSI_IDX_CHG_STATUS 8'h01
`define PMSI_IDX_REG_STATUS 8'h02
`define PMSI_IDX_CHG_MASK   8'h03
`define PMSI_IDX_REG_MASK   8'h04

// reset values and unmapped read value
`define PMSI_STATUS_RESET  8'h00
`define PMSI_MASK_RESET    8'hFF
`define PMSI_UNMAPPED_READ 8'hFF

// edge-set bit groups and software-clearable charge bits
`define PMSI_CHG_EDGE_BITS 8'h21
`define PMSI_REG_EDGE_BITS 8'hE0
`define PMSI_CHG_WRITABLE  8'h1E

// link transfer phases
`define PMSI_PHASE_ADDR  2'h0
`define PMSI_PHASE_INDEX 2'h1
`define PMSI_PHASE_DATA  2'h2

// bits per byte on the link
`define PMSI_BYTE_BITS 4'h8

// sync reset values of the link pins: clock and data idle high
`define PMSI_LINK_SYNC_INIT 11'h600

// taper timer: delay in minutes, clock period in ns, derived cycle count
`define PMSI_SYS_CLK_NS      50
`define PMSI_TAPER_DELAY_MIN 30
`define PMSI_NS_PER_MIN      64'h0000000DF8475800
`define PMSI_TAPER_DELAY_CYCLES \
	(36'((64'(`PMSI_TAPER_DELAY_MIN) * `PMSI_NS_PER_MIN) / 64'(`PMSI_SYS_CLK_NS)))

`endif

// file: logic/pmsi_pkg.sv
/*
 * Types of the power-manager serial status block.
 * Assumes the defines header sits beside it.
 */
`default_nettype none
package pmsi_pkg;

	// link controller states
	typedef enum logic [2:0] {
		LS_IDLE = 3'b000,	// waiting for a start
		LS_RECV = 3'b001,	// shifting a byte in
		LS_ACK  = 3'b010,	// acknowledge slot
		LS_SEND = 3'b011,	// shifting a byte out
		LS_MACK = 3'b100	// master acknowledge slot
	} pmsi_link_st_e;

	// register access passed from link to system domain
	typedef struct packed {
		logic       wr;	// write when set
		logic [7:0] index;	// register index
		logic [7:0] data;	// write data
	} pmsi_req_s;

	// charger conditions, msb first as in the status byte
	typedef struct packed {
		logic usbValid;
		logic acValid;
		logic thermalSuspend;
		logic termCurrent;
		logic taperCmp;
		logic chargeTimeout;
		logic prechargeTimeout;
		logic battTempError;
	} pmsi_chg_cond_s;

	// regulator conditions, msb first as in the status byte
	typedef struct packed {
		logic pushbuttonPowerRequest;
		logic battCoverLow;
		logic belowUvlo;
		logic noChargeSource;
		logic ldo2OutOfReg;
		logic ldo1OutOfReg;
		logic mainOutOfReg;
		logic coreOutOfReg;
	} pmsi_reg_cond_s;

	// supply and rail state
	typedef struct packed {
		logic       supplyAboveUvlo;
		logic       waitMode;
		logic [3:0] railRunning;	// main, core, ldo1, ldo2
	} pmsi_pwr_s;

	// control bits held in other registers of the device
	typedef struct packed {
		logic timerEnable;
		logic coreLowPwrCtl;
		logic lowPowerMode;
		logic ldo2Enable;
		logic ldo1Enable;
	} pmsi_ctl_s;

	// link-domain state
	typedef struct packed {
		pmsi_link_st_e st;
		logic [1:0]    phase;
		logic [3:0]    bitCnt;
		logic [7:0]    shift;
		logic [7:0]    index;
		logic          rnw;
		logic          reqTgl;
		pmsi_req_s     req;
		logic          sclPrev;
		logic          sdaPrev;
		logic          sdaOe;
		logic          sdaOut;
	} pmsi_link_s;

	// system-domain state
	typedef struct packed {
		logic [7:0]  chgStat;
		logic [7:0]  regStat;
		logic [7:0]  chgAck;
		logic [7:0]  regAck;
		logic [7:0]  chgMask;
		logic [7:0]  regMask;
		logic [7:0]  prevChg;
		logic [7:0]  prevReg;
		logic [35:0] taperCnt;
		logic [7:0]  rdData;
		logic        reqSeen;
		logic        chargerReset;
		logic        irqOe;
	} pmsi_sys_s;

endpackage
`default_nettype wire

// file: logic/pmsi_sync3.sv
/*
 * Three-flop input synchroniser with agreement filter.
 * Assumes an asynchronous active-low reset and a clock enable from the user.
 */
`timescale 1ns/1ps
`default_nettype none
module pmsi_sync3 #(
	parameter int          W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         en,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	// all state of the synchroniser
	typedef struct packed {
		logic [W-1:0] s1;	// metastable stage
		logic [W-1:0] s2;	// second stage
		logic [W-1:0] s3;	// third stage
		logic [W-1:0] q;	// accepted value
	} pmsi_sync_s;

	pmsi_sync_s sReg;	// registered state
	pmsi_sync_s sNext;	// next state

	// shift and accept bits where stages two and three agree
	always_comb begin
		sNext = sReg;
		if (en) begin
			sNext.s1 = d;
			sNext.s2 = sReg.s1;
			sNext.s3 = sReg.s2;
			sNext.q  = (sReg.s2 & ~(sReg.s2 ^ sReg.s3)) | (sReg.q & (sReg.s2 ^ sReg.s3));
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sReg <= {INIT, INIT, INIT, INIT};
		end else begin
			sReg <= sNext;
		end
	end

	assign q = sReg.q;

endmodule
`default_nettype wire

// file: logic/pmsi_status_regs.sv
/*
 * Two-wire serial slave with charge and regulator status, interrupt masks,
 * auto-acknowledge on status reads and an open-drain interrupt.
 * Assumes a free-running link clock for sampling the bus pins, separate
 * from sys_clk; analog status inputs are asynchronous levels.
 */
`include "pmsi_defines.svh"
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE_01] Answer address 100100 plus pin-set low bit
// [RULE_02] Unimplemented register reads return FFh
// [RULE_03] Data changes with clock low; start/stop
// [RULE_04] Acknowledge each byte by holding data low
// [RULE_05] Master gives ninth clock for acknowledge
// [RULE_06] Master nack ends read; device releases data
// [RULE_07] Interface works only with supply and rail
// [RULE_08] Waiting with all rails off resets registers
// [RULE_09] Charge bits 7,6 show USB, adapter present
// [RULE_10] Bit 5 thermal suspend, bit 4 termination
// [RULE_11] Bits 3-1 timeouts; bit 3 delayed 30 minutes
// [RULE_12] Bit 0 flags battery temperature out of range
// [RULE_13] Charge bits 1-4 clearable, rest write-ignored
// [RULE_14] Unmasked charge status bit drives interrupt
// [RULE_15] Regulator bits 7-4: button, cover, undervoltage, source
// [RULE_16] Bits 3,2 LDO fault, zero when disabled
// [RULE_17] Bit 1 main fault, bit 0 core fault
// [RULE_18] Rising regulator bit drives unmasked interrupt
// [RULE_19] Charge mask at 03h resets to FFh
// [RULE_20] Regulator mask at 04h resets to FFh
// [RULE_21] Status read acknowledges set bits, blocks interrupt
// [RULE_22] Charge bits 5,0 edge-set, clear after acknowledge
// [RULE_23] Regulator 7-5 edge-set, 3-0 follow level
// [RULE_24] One active-low open-drain interrupt output
// [RULE_25] Write: address, index, data; read via restart
module pmsi_status_regs #(
	parameter logic [35:0] TAPER_DELAY_CYCLES = `PMSI_TAPER_DELAY_CYCLES
) (
	// system clock, reset and clock enable
	input  wire logic                     sys_clk,
	input  wire logic                     reset_n,
	input  wire logic                     clkEn,
	// link clock that samples the bus pins
	input  wire logic                     linkClk,
	// two-wire bus pins
	input  wire logic                     scl,
	input  wire logic                     sdaIn,
	output logic                          sdaOut,
	output logic                          sdaOe,
	input  wire logic                     busAddrLowBitPin,
	// analog conditions and control bits
	input  wire pmsi_pkg::pmsi_chg_cond_s chgCond,
	input  wire pmsi_pkg::pmsi_reg_cond_s regCond,
	input  wire pmsi_pkg::pmsi_pwr_s      pwr,
	input  wire pmsi_pkg::pmsi_ctl_s      ctl,
	// charger reset request and interrupt pin
	output logic                          chargerResetPulse,
	output logic                          irqOe
);

	// link-domain synchronised inputs
	logic [10:0]         lSyncQ;	// synchroniser outputs
	logic                lScl;	// bus clock
	logic                lSda;	// bus data
	logic                lAddrPin;	// address low bit
	pmsi_pkg::pmsi_pwr_s lPwr;	// supply and rails
	logic                lAck;	// echo of the last request toggle
	logic                lEn;	// clock enable
	logic                lIfaceOk;	// interface allowed to run
	logic                lSclRise;	// bus clock rising
	logic                lSclFall;	// bus clock falling
	logic                lStart;	// start or repeated start
	logic                lStop;	// stop
	logic [7:0]          lByte;	// byte with the bit sampled now

	// system-domain synchronised inputs
	logic [27:0]              sSyncQ;	// synchroniser outputs
	pmsi_pkg::pmsi_chg_cond_s sChg;	// charger conditions
	pmsi_pkg::pmsi_reg_cond_s sRegC;	// regulator conditions
	pmsi_pkg::pmsi_ctl_s      sCtl;	// control bits
	pmsi_pkg::pmsi_pwr_s      sPwr;	// supply and rails
	logic                     sReqTgl;	// request toggle from link
	logic                     sReqNew;	// request pending
	logic                     sRdChg;	// charge status read now
	logic                     sRdReg;	// regulator status read now
	logic                     sWr;	// write request now
	logic                     sAllOff;	// waiting with every rail off
	logic                     sTaperFlag;	// effective taper bit
	logic [7:0]               sChgEff;	// charge conditions as a byte
	logic [7:0]               sRegEff;	// regulator conditions as a byte
	logic [7:0]               sChgRise;	// charge conditions rising
	logic [7:0]               sWrClr;	// charge bits cleared by write

	pmsi_pkg::pmsi_link_s lReg;	// link state
	pmsi_pkg::pmsi_link_s lNext;	// next link state
	pmsi_pkg::pmsi_sys_s  sReg;	// system state
	pmsi_pkg::pmsi_sys_s  sNext;	// next system state

	// address compare on a received byte
	function automatic logic addrMatch(input logic [7:0] b, input logic pin);
		return b[7:1] == {`PMSI_ADDR_FIXED, pin};	// RULE_01
	endfunction

	// next value of a status byte with edge and level bits
	function automatic logic [7:0] statusNext(
		input logic [7:0] stat,
		input logic [7:0] ack,
		input logic [7:0] cond,
		input logic [7:0] prev,
		input logic [7:0] edgeMask
	);
		logic [7:0] edgeVal;
		edgeVal = (cond & ~prev) | (stat & ~(~cond & ack));	// RULE_22 RULE_23
		return (edgeMask & edgeVal) | (~edgeMask & cond);
	endfunction

	// acknowledge byte: set by a read of set bits, gone with the status bit
	function automatic logic [7:0] ackNext(
		input logic [7:0] ack,
		input logic [7:0] stat,
		input logic [7:0] newStat,
		input logic       rd
	);
		return (ack | (rd ? stat : 8'h00)) & newStat;	// RULE_21
	endfunction

	// hand a register access to the system domain and advance the index
	function automatic pmsi_pkg::pmsi_link_s postReq(
		input pmsi_pkg::pmsi_link_s s,
		input logic                 wr,
		input logic [7:0]           d
	);
		pmsi_pkg::pmsi_link_s r;
		r = s;
		r.reqTgl = ~s.reqTgl;
		r.req.wr = wr;
		r.req.index = s.index;
		r.req.data = d;
		r.index = s.index + 8'h01;
		return r;
	endfunction

	// system state after reset or all-rails-off wait
	function automatic pmsi_pkg::pmsi_sys_s sysDefault();
		pmsi_pkg::pmsi_sys_s r;
		r = '0;
		r.chgStat = `PMSI_STATUS_RESET;
		r.regStat = `PMSI_STATUS_RESET;
		r.chgMask = `PMSI_MASK_RESET;	// RULE_19
		r.regMask = `PMSI_MASK_RESET;	// RULE_20
		return r;
	endfunction

	// link-domain synchroniser for pins and the request echo
	pmsi_sync3 #(
		.W    (11),
		.INIT (`PMSI_LINK_SYNC_INIT)
	) linkSync (
		.clk   (linkClk),
		.rst_n (reset_n),
		.en    (1'b1),
		.d     ({scl, sdaIn, busAddrLowBitPin, pwr, sReg.reqSeen, clkEn}),
		.q     (lSyncQ)
	);

	// system-domain synchroniser for conditions and the request toggle
	pmsi_sync3 #(
		.W    (28),
		.INIT (28'h0000000)
	) sysSync (
		.clk   (sys_clk),
		.rst_n (reset_n),
		.en    (clkEn),
		.d     ({chgCond, regCond, ctl, pwr, lReg.reqTgl}),
		.q     (sSyncQ)
	);

	// link-side decode of bus conditions
	assign {lScl, lSda, lAddrPin, lPwr, lAck, lEn} = lSyncQ;
	assign lIfaceOk = lPwr.supplyAboveUvlo & (|lPwr.railRunning);	// RULE_07
	assign lSclRise = lScl & ~lReg.sclPrev;
	assign lSclFall = ~lScl & lReg.sclPrev;
	assign lStart   = lScl & lReg.sclPrev & ~lSda & lReg.sdaPrev;	// RULE_03
	assign lStop    = lScl & lReg.sclPrev & lSda & ~lReg.sdaPrev;	// RULE_03
	assign lByte    = {lReg.shift[6:0], lSda};

	// link controller: bytes in, acknowledges, bytes out
	always_comb begin
		lNext = lReg;
		if (lEn) begin
			lNext.sclPrev = lScl;
			lNext.sdaPrev = lSda;
			if (!lIfaceOk) begin
				// inactive: ignore the bus, release data
				lNext.st = pmsi_pkg::LS_IDLE;	// RULE_07
				lNext.sdaOe = 1'b0;
			end else if (lStart) begin
				// start or repeated start opens an address byte
				lNext.st = pmsi_pkg::LS_RECV;	// RULE_25
				lNext.phase = `PMSI_PHASE_ADDR;
				lNext.bitCnt = 4'h0;
				lNext.sdaOe = 1'b0;
			end else if (lStop) begin
				// stop ends the transfer
				lNext.st = pmsi_pkg::LS_IDLE;
				lNext.sdaOe = 1'b0;
			end else begin
				case (lReg.st)
					pmsi_pkg::LS_RECV: begin
						if (lSclRise) begin
							// sample a bit with the clock high
							lNext.shift = lByte;	// RULE_03
							lNext.bitCnt = lReg.bitCnt + 4'h1;
							if (lReg.bitCnt == `PMSI_BYTE_BITS - 4'h1) begin
								case (lReg.phase)
									`PMSI_PHASE_ADDR: begin
										// read address posts the first read
										if (addrMatch(lByte, lAddrPin)) begin
											lNext.rnw = lByte[0];
											if (lByte[0]) begin
												lNext = postReq(lNext, 1'b0, 8'h00);	// RULE_25
											end
										end
									end
									`PMSI_PHASE_INDEX: begin
										// register index byte
										lNext.index = lByte;	// RULE_25
									end
									default: begin
										// data byte: write and advance
										lNext = postReq(lNext, 1'b1, lByte);	// RULE_25
									end
								endcase
							end
						end else if (lSclFall && lReg.bitCnt == `PMSI_BYTE_BITS) begin
							// byte done: acknowledge if addressed
							if (lReg.phase != `PMSI_PHASE_ADDR || addrMatch(lReg.shift, lAddrPin)) begin
								lNext.st = pmsi_pkg::LS_ACK;
								lNext.sdaOe = 1'b1;	// RULE_04
							end else begin
								lNext.st = pmsi_pkg::LS_IDLE;
							end
						end
					end
					pmsi_pkg::LS_ACK: begin
						if (lSclFall) begin
							if (lReg.phase == `PMSI_PHASE_ADDR && lReg.rnw) begin
								// load read byte after the acknowledge clock
								lNext.shift = (lAck == lReg.reqTgl) ? sReg.rdData : `PMSI_UNMAPPED_READ;
								lNext.sdaOe = ~lNext.shift[7];
								lNext.bitCnt = 4'h0;
								lNext.st = pmsi_pkg::LS_SEND;
							end else begin
								// release after the acknowledge clock
								lNext.sdaOe = 1'b0;	// RULE_04 RULE_05
								lNext.bitCnt = 4'h0;
								lNext.st = pmsi_pkg::LS_RECV;
								lNext.phase = (lReg.phase == `PMSI_PHASE_ADDR) ? `PMSI_PHASE_INDEX
									: `PMSI_PHASE_DATA;
							end
						end
					end
					pmsi_pkg::LS_SEND: begin
						if (lSclRise) begin
							// master samples the bit
							lNext.bitCnt = lReg.bitCnt + 4'h1;
						end else if (lSclFall) begin
							if (lReg.bitCnt == `PMSI_BYTE_BITS) begin
								// free data for the master's acknowledge
								lNext.sdaOe = 1'b0;	// RULE_05
								lNext.st = pmsi_pkg::LS_MACK;
							end else begin
								// next bit changes only with the clock low
								lNext.shift = {lReg.shift[6:0], 1'b0};	// RULE_03
								lNext.sdaOe = ~lReg.shift[6];
							end
						end
					end
					pmsi_pkg::LS_MACK: begin
						if (lSclRise) begin
							if (!lSda) begin
								// acknowledged: fetch the next byte
								lNext = postReq(lNext, 1'b0, 8'h00);
								lNext.st = pmsi_pkg::LS_ACK;
							end else begin
								// not acknowledged: keep data released
								lNext.st = pmsi_pkg::LS_IDLE;	// RULE_06
							end
						end
					end
					default: begin
						// idle: wait for a start
						lNext.sdaOe = 1'b0;
					end
				endcase
			end
		end
	end

	// link state register
	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			lReg <= '{st: pmsi_pkg::LS_IDLE, sclPrev: 1'b1, sdaPrev: 1'b1, default: '0};
		end else begin
			lReg <= lNext;
		end
	end

	// system-side decode of conditions and requests
	assign {sChg, sRegC, sCtl, sPwr, sReqTgl} = sSyncQ;
	assign sReqNew = sReqTgl != sReg.reqSeen;
	assign sWr     = sReqNew & lReg.req.wr;
	assign sRdChg  = sReqNew & ~lReg.req.wr & (lReg.req.index == `PMSI_IDX_CHG_STATUS);
	assign sRdReg  = sReqNew & ~lReg.req.wr & (lReg.req.index == `PMSI_IDX_REG_STATUS);
	assign sAllOff = sPwr.waitMode & ~(|sPwr.railRunning);	// RULE_08

	// taper bit: comparator directly, or after the timer runs out
	assign sTaperFlag = sCtl.timerEnable ? (sReg.taperCnt >= TAPER_DELAY_CYCLES) : sChg.taperCmp;	// RULE_11

	// charge conditions: sources, thermal, termination, timeouts, temperature
	assign sChgEff = {sChg.usbValid, sChg.acValid, sChg.thermalSuspend, sChg.termCurrent,	// RULE_09 RULE_10
		sTaperFlag, sChg.chargeTimeout, sChg.prechargeTimeout, sChg.battTempError};	// RULE_11 RULE_12

	// regulator conditions; disabled LDOs never report a fault
	assign sRegEff = {sRegC.pushbuttonPowerRequest, sRegC.battCoverLow, sRegC.belowUvlo,	// RULE_15
		sRegC.noChargeSource,
		sRegC.ldo2OutOfReg & sCtl.ldo2Enable, sRegC.ldo1OutOfReg & sCtl.ldo1Enable,	// RULE_16
		sRegC.mainOutOfReg, sRegC.coreOutOfReg | (sCtl.coreLowPwrCtl & sCtl.lowPowerMode)};	// RULE_17

	// software clear of charge bits 1-4; a new event in that cycle wins
	assign sChgRise = sChgEff & ~sReg.prevChg;
	assign sWrClr = (sWr && lReg.req.index == `PMSI_IDX_CHG_STATUS)
		? (`PMSI_CHG_WRITABLE & ~lReg.req.data & ~sChgRise) : 8'h00;	// RULE_13

	// status, acknowledge, masks, reads and the interrupt
	always_comb begin
		sNext = sReg;
		if (clkEn) begin
			if (sAllOff) begin
				// defaults while waiting with every rail off
				sNext = sysDefault();	// RULE_08
				sNext.reqSeen = sReqTgl;
			end else begin
				// status bytes and acknowledge bytes
				sNext.chgStat = statusNext(sReg.chgStat, sReg.chgAck, sChgEff, sReg.prevChg,
					`PMSI_CHG_EDGE_BITS) & ~sWrClr;	// RULE_22 RULE_13
				sNext.regStat = statusNext(sReg.regStat, sReg.regAck, sRegEff, sReg.prevReg,
					`PMSI_REG_EDGE_BITS);	// RULE_23 RULE_18
				sNext.chgAck = ackNext(sReg.chgAck, sReg.chgStat, sNext.chgStat, sRdChg);	// RULE_21
				sNext.regAck = ackNext(sReg.regAck, sReg.regStat, sNext.regStat, sRdReg);	// RULE_21
				sNext.prevChg = sChgEff;
				sNext.prevReg = sRegEff;
				// charger reset when a set bit is cleared by software
				sNext.chargerReset = |(sWrClr & sReg.chgStat);	// RULE_13
				// taper timer runs while the comparator holds and timers are on
				if (!sChg.taperCmp || !sCtl.timerEnable || sReg.chargerReset) begin
					sNext.taperCnt = 36'h000000000;
				end else if (sReg.taperCnt < TAPER_DELAY_CYCLES) begin
					sNext.taperCnt = sReg.taperCnt + 36'h000000001;	// RULE_11
				end
				// register access from the link
				if (sReqNew) begin
					sNext.reqSeen = sReqTgl;
					if (lReg.req.wr) begin
						case (lReg.req.index)
							`PMSI_IDX_CHG_MASK: sNext.chgMask = lReg.req.data;	// RULE_19
							`PMSI_IDX_REG_MASK: sNext.regMask = lReg.req.data;	// RULE_20
							default: begin
								// status and unmapped writes store nothing
								sNext.chgMask = sReg.chgMask;
							end
						endcase
					end else begin
						case (lReg.req.index)
							`PMSI_IDX_CHG_STATUS: sNext.rdData = sReg.chgStat;
							`PMSI_IDX_REG_STATUS: sNext.rdData = sReg.regStat;
							`PMSI_IDX_CHG_MASK:   sNext.rdData = sReg.chgMask;
							`PMSI_IDX_REG_MASK:   sNext.rdData = sReg.regMask;
							default:              sNext.rdData = `PMSI_UNMAPPED_READ;	// RULE_02
						endcase
					end
				end
				// unmasked, unacknowledged status pulls the interrupt low
				sNext.irqOe = |(sReg.chgStat & ~sReg.chgMask & ~sReg.chgAck)	// RULE_14
					| |(sReg.regStat & ~sReg.regMask & ~sReg.regAck);	// RULE_18 RULE_24
			end
		end
	end

	// system state register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sReg <= sysDefault();
		end else begin
			sReg <= sNext;
		end
	end

	// outputs straight from flops
	assign sdaOut            = lReg.sdaOut;
	assign sdaOe             = lReg.sdaOe;
	assign chargerResetPulse = sReg.chargerReset;
	assign irqOe             = sReg.irqOe;

endmodule
`default_nettype wire

// file: dv/pmsi_status_regs_chk.sv
/* pin-level assertions for the status block.
   bound to every pmsi_status_regs instance */
`timescale 1ns/1ps
`default_nettype none
module pmsi_status_regs_chk (
	// clocks and reset
	input wire logic                sys_clk,
	input wire logic                linkClk,
	input wire logic                reset_n,
	input wire logic                clkEn,
	// bus pins
	input wire logic                scl,
	input wire logic                sdaOut,
	input wire logic                sdaOe,
	// power state and outputs
	input wire pmsi_pkg::pmsi_pwr_s pwr,
	input wire logic                chargerResetPulse,
	input wire logic                irqOe
);
	// data pin only ever pulls low
	AST_SDA_LOW: assert property (@(posedge linkClk) disable iff (!reset_n) sdaOe |-> !sdaOut)
		else $error("data pin driven high");
	// data moves only while the bus clock is low
	AST_EDGE_LOW: assert property (@(posedge linkClk) disable iff (!reset_n) $changed(sdaOe) |-> !scl)
		else $error("data changed with clock high");
	// long clock-high idle means the line is free
	AST_IDLE_FREE: assert property (@(posedge linkClk) disable iff (!reset_n) scl[*8] |-> !sdaOe)
		else $error("data held at idle");
	// every drive of the line ends in bounded time
	AST_RELEASE: assert property (@(posedge linkClk) disable iff (!reset_n) $rose(sdaOe) |-> ##[1:300] !sdaOe)
		else $error("data never released");
	// no answer without supply
	AST_NO_SUPPLY: assert property (@(posedge linkClk) disable iff (!reset_n)
		(!pwr.supplyAboveUvlo)[*8] |-> !sdaOe)
		else $error("answer without supply");
	// masks start set, so no interrupt after reset
	AST_MASK_RESET: assert property (@(posedge sys_clk) disable iff (!reset_n) $rose(reset_n) |-> !irqOe[*8])
		else $error("interrupt after reset");
	// waiting with rails off restores masks
	AST_WAIT_DEFAULT: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(clkEn && pwr.waitMode && pwr.railRunning == 4'h0)[*8] |-> ##2 !irqOe)
		else $error("interrupt in wait with rails off");
	// charger reset is a single cycle pulse
	AST_PULSE_ONE: assert property (@(posedge sys_clk) disable iff (!reset_n) $rose(chargerResetPulse) |=> !chargerResetPulse)
		else $error("charger reset pulse too long");
endmodule
bind pmsi_status_regs pmsi_status_regs_chk u_chk (.sys_clk(sys_clk), .linkClk(linkClk), .reset_n(reset_n),
	.clkEn(clkEn), .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe), .pwr(pwr),
	.chargerResetPulse(chargerResetPulse), .irqOe(irqOe));
`default_nettype wire

// file: dv/pmsi_bus_master.sv
/* two-wire bus master model stepping on linkClk.
   the bench resolves the open-drain data wire with a pull-up */
`include "pmsi_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module pmsi_bus_master (
	// step clock, wire level, address low bit to send
	input wire logic linkClk,
	input wire logic sda,
	input wire logic lowBit,
	// master pins
	output logic     scl,
	output logic     sdaLow
);
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	// wait n link cycles, step off the edge
	task automatic hp(input int n);
		repeat (n) @(posedge linkClk);
		#1;
	endtask
	// one bit: data set with clock low, sampled late in the high phase
	task automatic bitx(input logic b, output logic r);
		sdaLow = !b;
		hp(4);
		scl = 1'b1;
		hp(6);
		r = sda;
		scl = 1'b0;
		hp(4);
	endtask
	// start or repeated start
	task automatic sta();
		sdaLow = 1'b0;
		hp(4);
		scl = 1'b1;
		hp(4);
		sdaLow = 1'b1;
		hp(4);
		scl = 1'b0;
		hp(4);
	endtask
	// stop: data rises with clock high
	task automatic sto();
		sdaLow = 1'b1;
		hp(4);
		scl = 1'b1;
		hp(4);
		sdaLow = 1'b0;
		hp(8);
	endtask
	// eight bits msb first, then the acknowledge clock
	task automatic byt(input logic [7:0] tx, output logic [7:0] rx, output logic a);
		for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
		bitx(1'b1, a);
	endtask
	// address, index, data
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic nak);
		logic [7:0] r;
		logic       a0, a1, a2;
		sta();
		byt({`PMSI_ADDR_FIXED, lowBit, 1'b0}, r, a0);
		byt(idx, r, a1);
		byt(d, r, a2);
		sto();
		nak = a0 | a1 | a2;
	endtask
	// index write, restart, one byte read and not acknowledged
	task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic nak);
		logic [7:0] r;
		logic       a0, a1, a2, a3;
		sta();
		byt({`PMSI_ADDR_FIXED, lowBit, 1'b0}, r, a0);
		byt(idx, r, a1);
		sta();
		byt({`PMSI_ADDR_FIXED, lowBit, 1'b1}, r, a2);
		byt(8'hFF, d, a3);
		sto();
		nak = a0 | a1 | a2;
	endtask
endmodule
`default_nettype wire

// file: dv/pmsi_status_regs_test.sv
/* self-checking bench: register access through the bus master model.
   needs the defines header on the include path */
`timescale 1ns/1ps
`default_nettype none
module pmsi_status_regs_test;
	logic                     sys_clk, linkClk, reset_n, clkEn, pin, mstBit;
	logic                     scl, mstLow, sdaOe, sdaOut, pulse, irqOe, nak;
	wire logic                sda;
	pmsi_pkg::pmsi_chg_cond_s chgCond;
	pmsi_pkg::pmsi_reg_cond_s regCond;
	pmsi_pkg::pmsi_pwr_s      pwr;
	pmsi_pkg::pmsi_ctl_s      ctl;
	int                       error_cnt, checks, pulses;
	logic [7:0]               d;
	// open-drain data wire with pull-up
	assign sda = !(sdaOe | mstLow);
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = !sys_clk;
	end
	initial begin
		linkClk = 1'b0;
		#7;
		forever #80 linkClk = !linkClk;
	end
	pmsi_status_regs #(.TAPER_DELAY_CYCLES(36'd100)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn),
		.linkClk(linkClk), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .busAddrLowBitPin(pin),
		.chgCond(chgCond), .regCond(regCond), .pwr(pwr), .ctl(ctl), .chargerResetPulse(pulse), .irqOe(irqOe));
	pmsi_bus_master m (.linkClk(linkClk), .sda(sda), .lowBit(mstBit), .scl(scl), .sdaLow(mstLow));
	// charger reset pulse counter
	always @(posedge sys_clk) if (pulse === 1'b1) pulses++;
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		m.rd(idx, d, nak);
		chk({nak, d}, {1'b0, exp});
	endtask
	task automatic wrc(input logic [7:0] idx, input logic [7:0] v, input logic expNak);
		m.wr(idx, v, nak);
		chk({8'h00, nak}, {8'h00, expNak});
	endtask
	// wait n system cycles, drive just after the edge
	task automatic st(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// watchdog
	initial begin
		#4000000;
		error_cnt++;
		$display("CHECK FAILED at %0t: timeout", $time);
		report_and_stop();
	end
	initial begin
		reset_n = 1'b0;
		clkEn = 1'b1;
		pin = 1'b1;
		mstBit = 1'b1;
		chgCond = 8'h00;
		regCond = 8'h00;
		ctl = 5'h00;
		pwr = 6'h21;
		st(2);
		reset_n = 1'b1;
		st(20);
		// defaults and an unmapped index
		rdc(8'h01, 8'h00);
		rdc(8'h02, 8'h00);
		rdc(8'h03, 8'hFF);
		rdc(8'h04, 8'hFF);
		rdc(8'h05, 8'hFF);
		chk({8'h00, irqOe}, 9'h000);
		$display("test defaults done");
		// regulator: edge bit, gated ldo, low-power core
		wrc(8'h04, 8'h00, 1'b0);
		ctl = 5'h0D;
		regCond = 8'h8C;
		st(10);
		regCond = 8'h0C;
		st(10);
		chk({8'h00, irqOe}, 9'h001);
		rdc(8'h02, 8'h85);
		chk({8'h00, irqOe}, 9'h000);
		rdc(8'h02, 8'h05);
		ctl = 5'h01;
		regCond = 8'h00;
		st(10);
		rdc(8'h02, 8'h00);
		$display("test regulator done");
		// charge: edge and level bits, clear by write
		wrc(8'h03, 8'h00, 1'b0);
		chgCond = 8'hB9;
		st(10);
		chgCond = 8'h98;
		st(10);
		chk({8'h00, irqOe}, 9'h001);
		rdc(8'h01, 8'hB9);
		chk({8'h00, irqOe}, 9'h000);
		wrc(8'h01, 8'h00, 1'b0);
		chk({1'b0, pulses[7:0]}, 9'h001);
		chgCond = 8'h00;
		st(10);
		wrc(8'h01, 8'hFF, 1'b0);
		rdc(8'h01, 8'h00);
		$display("test charge done");
		// wrong address is ignored
		mstBit = 1'b0;
		wrc(8'h03, 8'h12, 1'b1);
		pin = 1'b0;
		st(10);
		rdc(8'h03, 8'h00);
		$display("test address done");
		// no rail, then wait with rails off
		pwr = 6'h20;
		wrc(8'h03, 8'h12, 1'b1);
		pwr = 6'h21;
		st(10);
		rdc(8'h03, 8'h00);
		pwr = 6'h30;
		st(20);
		pwr = 6'h21;
		st(10);
		rdc(8'h03, 8'hFF);
		rdc(8'h04, 8'hFF);
		$display("test power done");
		report_and_stop();
	end
endmodule
`default_nettype wire
